// ==== verif/capture_record_formatter_tb.sv ====
// Bench for the capture record formatter with a host sink model.
`timescale 1ns/1ns
`default_nettype none
module capture_record_formatter_tb;
  logic MCLK, RESET_N, CLK_EN, IN_VALID, IN_READY, IN_SOP, IN_EOP, IN_IS_ETHERNET, IN_RX_ERROR;
  logic IN_DATAPATH_ERROR, DROP, VARLEN_MODE, OUT_VALID, OUT_READY, OUT_SOR, OUT_EOR, BUSY, hold, jitter, trunc;
  logic [7:0] IN_DATA, ETH_OFFSET, OUT_DATA;
  logic [1:0] IN_IFACE;
  logic [15:0] IN_CAP_LEN, IN_WIRE_LEN, SPACE_AVAIL, loss, hl, rl, c, sp, want;
  logic [31:0] TS_SECONDS, TS_FRACTION, seed;
  logic [7:0] pl [64];
  logic [9:0] exp_q [$];
  int num_errors, checked;
  capture_record_formatter u_capture_record_formatter (.MCLK, .RESET_N, .CLK_EN, .IN_VALID, .IN_READY, .IN_DATA,
    .IN_SOP, .IN_EOP, .IN_IFACE, .IN_IS_ETHERNET, .IN_CAP_LEN, .IN_WIRE_LEN, .IN_RX_ERROR, .IN_DATAPATH_ERROR,
    .DROP, .TS_SECONDS, .TS_FRACTION, .VARLEN_MODE, .ETH_OFFSET, .SPACE_AVAIL, .OUT_VALID, .OUT_READY, .OUT_DATA,
    .OUT_SOR, .OUT_EOR, .BUSY);
  record_sink_model u_record_sink_model (.clk(MCLK), .rst_n(RESET_N), .hold(hold), .ready(OUT_READY));
  ////////////////////////////////////////
  function automatic logic [31:0] rng();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rng
  function automatic logic [7:0] hbyte(input int i);
    logic [63:0] ts;
    ts = {TS_SECONDS, TS_FRACTION[31:4], 4'h0};
    case (i)
      0, 1, 2, 3, 4, 5, 6, 7: return ts[8 * i +: 8];
      8: return IN_IS_ETHERNET ? 8'h02 : 8'h01;
      9: return {2'b00, IN_DATAPATH_ERROR, IN_RX_ERROR, trunc, VARLEN_MODE, IN_IFACE};
      10: return rl[15:8];
      11: return rl[7:0];
      12: return loss[15:8];
      13: return loss[7:0];
      14: return IN_WIRE_LEN[15:8];
      15: return IN_WIRE_LEN[7:0];
      16: return IN_IS_ETHERNET ? ETH_OFFSET : pl[0];
      17: return IN_IS_ETHERNET ? 8'h00 : pl[1];
      default: return pl[i - hl];
    endcase
  endfunction : hbyte
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic drops(input int n);
    jitter <= 1'b0;
    repeat (2) @(posedge MCLK);
    for (int i = 0; i < n; i++) begin
      DROP <= 1'b1;
      if (loss != 16'hFFFF) loss++;
      @(posedge MCLK);
    end
    DROP <= 1'b0;
  endtask : drops
  task automatic send(input logic e, input logic [15:0] cap, input logic [15:0] space);
    logic [31:0] r;
    int n;
    int t;
    r = rng();
    for (int i = 0; i < 64; i++) pl[i] = 8'(rng());
    @(posedge MCLK);
    IN_IS_ETHERNET <= e;
    IN_CAP_LEN <= cap;
    SPACE_AVAIL <= space;
    {IN_WIRE_LEN, ETH_OFFSET, VARLEN_MODE, IN_DATAPATH_ERROR, IN_RX_ERROR, IN_IFACE} <= r[28:0];
    TS_SECONDS <= rng();
    TS_FRACTION <= rng();
    IN_DATA <= pl[0];
    IN_SOP <= 1'b1;
    IN_EOP <= (cap == 16'h0001);
    IN_VALID <= 1'b1;
    #1;
    hl = e ? 16'h0012 : 16'h0010;
    rl = (hl + cap <= space) ? hl + cap : (space < hl) ? hl : space;
    trunc = rl < hl + cap;
    for (int i = 0; i < rl; i++) exp_q.push_back({i == 0, i == rl - 1, hbyte(i)});
    loss = 16'h0000;
    n = 0;
    t = 0;
    while (n < cap && t < 3000) begin
      @(posedge MCLK);
      t++;
      if (IN_READY === 1'b1) begin
        n++;
        IN_SOP <= 1'b0;
        IN_DATA <= pl[n];
        IN_EOP <= (n == cap - 1);
      end
    end
    IN_VALID <= 1'b0;
    if (t >= 3000) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : send
  ////////////////////////////////////////
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) CLK_EN <= !jitter || (rng() % 8 != 0);
  always @(posedge MCLK) begin
    if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
      want = exp_q.size() > 0 ? {6'h00, exp_q.pop_front()} : 16'hFFFF;
      check("record byte", {6'h00, OUT_SOR, OUT_EOR, OUT_DATA}, want);
    end
  end
  initial begin
    seed = 32'hF735;
    {RESET_N, CLK_EN, IN_VALID, IN_SOP, IN_EOP, IN_IS_ETHERNET, IN_RX_ERROR, IN_DATAPATH_ERROR} = '0;
    {DROP, VARLEN_MODE, hold, jitter, loss} = '0;
    {IN_DATA, ETH_OFFSET, IN_IFACE, IN_CAP_LEN, IN_WIRE_LEN, SPACE_AVAIL, TS_SECONDS, TS_FRACTION} = '0;
    repeat (2) @(posedge MCLK);
    RESET_N <= 1'b1;
    // First three records: header only, exact fit, one byte short
    for (int k = 0; k < 24; k++) begin
      drops(rng() % 4);
      jitter <= 1'b1;
      c = 16'(1 + rng() % 40);
      sp = (k == 0) ? 16'h000A : (k < 3) ? (k[0] ? 16'h0012 : 16'h0010) + c - 16'(k - 1) :
        (rng() % 2) ? 16'hFFFF : 16'(16 + rng() % 48);
      send(k[0], c, sp);
    end
    $display("test random_records done");
    // Enable held high so the stalled handshake is seen steady
    jitter <= 1'b0;
    hold <= 1'b1;
    fork
      send(1'b1, 16'h0028, 16'hFFFF);
      begin
        repeat (60) @(posedge MCLK);
        check("in_ready", {15'h0000, IN_READY}, 16'h0000);
        check("out_valid", {15'h0000, OUT_VALID}, 16'h0001);
        check("busy_stalled", {15'h0000, BUSY}, 16'h0001);
        hold <= 1'b0;
      end
    join
    $display("test buffer_stall done");
    drops(65540);
    send(1'b0, 16'h0004, 16'hFFFF);
    send(1'b1, 16'h0004, 16'hFFFF);
    $display("test loss_saturation done");
    for (int t = 0; t < 2000 && exp_q.size() > 0; t++) @(posedge MCLK);
    check("drained", 16'(exp_q.size()), 16'h0000);
    @(posedge MCLK);
    check("busy_idle", {15'h0000, BUSY}, 16'h0000);
    tally_and_finish();
  end
endmodule : capture_record_formatter_tb
bind capture_record_formatter capture_record_monitor u_capture_record_monitor (.MCLK, .RESET_N, .CLK_EN, .IN_VALID,
  .IN_READY, .IN_SOP, .IN_EOP, .IN_IFACE, .IN_WIRE_LEN, .TS_SECONDS, .TS_FRACTION, .OUT_VALID, .OUT_READY,
  .OUT_DATA, .OUT_SOR, .OUT_EOR);
`default_nettype wire

// ==== verif/capture_record_monitor.sv ====
// Port-level assertions for the capture record formatter.
`timescale 1ns/1ns
`default_nettype none
module capture_record_monitor (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic IN_VALID,
  input wire logic IN_READY,
  input wire logic IN_SOP,
  input wire logic IN_EOP,
  input wire logic [1:0] IN_IFACE,
  input wire logic [15:0] IN_WIRE_LEN,
  input wire logic [31:0] TS_SECONDS,
  input wire logic [31:0] TS_FRACTION,
  input wire logic OUT_VALID,
  input wire logic OUT_READY,
  input wire logic [7:0] OUT_DATA,
  input wire logic OUT_SOR,
  input wire logic OUT_EOR
);
  logic [15:0] cnt, rlen, wlen, pwlen;
  logic [63:0] ts, pts;
  logic [7:0] typ;
  logic [1:0] ifc, pifc;
  logic idle;
  wire fire = OUT_VALID && OUT_READY;
  wire [15:0] idx = OUT_SOR ? 16'h0000 : cnt;
  wire start = idle && CLK_EN && IN_VALID && IN_SOP;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////
  // Descriptor parked at start, made current when its first byte leaves:
  // the next packet may start while late header bytes still sit in the buffer
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {cnt, rlen, wlen, ts, typ, ifc} <= '0;
      {pwlen, pts, pifc} <= '0;
      idle <= 1'b1;
    end else begin
      if (fire) cnt <= idx + 16'h0001;
      if (fire && OUT_SOR) {ts, wlen, ifc} <= {pts, pwlen, pifc};
      if (fire && idx == 16'h0008) typ <= OUT_DATA;
      if (fire && idx == 16'h000A) rlen[15:8] <= OUT_DATA;
      if (fire && idx == 16'h000B) rlen[7:0] <= OUT_DATA;
      if (start) begin
        idle <= 1'b0;
        pts <= {TS_SECONDS, TS_FRACTION};
        pwlen <= IN_WIRE_LEN;
        pifc <= IN_IFACE;
      end else if (IN_VALID && IN_READY && IN_EOP) idle <= 1'b1;
    end
  end
  ////////////////////////////////////////
  property p_ts_lo; fire && OUT_SOR |-> OUT_DATA == {pts[7:4], 4'h0}; endproperty
  a_ts_lo: assert property (p_ts_lo) else $error("timestamp low byte wrong");
  property p_ts_hi; fire && idx == 16'h0007 |-> OUT_DATA == ts[63:56]; endproperty
  a_ts_hi: assert property (p_ts_hi) else $error("timestamp high byte wrong");
  property p_type; fire && idx == 16'h0008 |-> OUT_DATA inside {8'h01, 8'h02}; endproperty
  a_type: assert property (p_type) else $error("record type not produced here");
  property p_flags; fire && idx == 16'h0009 |-> OUT_DATA[1:0] == ifc && OUT_DATA[7:6] == 2'b00; endproperty
  a_flags: assert property (p_flags) else $error("flags byte wrong");
  property p_wlen; fire && idx == 16'h000E |-> OUT_DATA == wlen[15:8]; endproperty
  a_wlen: assert property (p_wlen) else $error("wire length high byte wrong");
  property p_rlen; fire && OUT_EOR |-> idx + 16'h0001 == rlen && idx >= 16'h000F; endproperty
  a_rlen: assert property (p_rlen) else $error("record length differs from bytes sent");
  property p_pad; fire && idx == 16'h0011 && typ == 8'h02 |-> OUT_DATA == 8'h00; endproperty
  a_pad: assert property (p_pad) else $error("pad byte not zero");
  property p_hold; OUT_VALID && !OUT_READY ##1 CLK_EN |-> OUT_VALID && $stable({OUT_DATA, OUT_SOR, OUT_EOR}); endproperty
  a_hold: assert property (p_hold) else $error("stalled output byte changed");
  property p_start; start |-> ##[1:100] (OUT_VALID && OUT_SOR); endproperty
  a_start: assert property (p_start) else $error("no record began after packet start");
  c_eth: cover property (fire && idx == 16'h0011 && typ == 8'h02);
  c_trunc: cover property (fire && idx == 16'h0009 && OUT_DATA[3]);
  c_stall: cover property (OUT_VALID && !OUT_READY [*3]);
  c_sat: cover property (fire && idx == 16'h000C && OUT_DATA == 8'hFF);
endmodule : capture_record_monitor
`default_nettype wire

// ==== verif/record_sink_model.sv ====
// Host-side record sink: takes record bytes under random back-pressure.
`timescale 1ns/1ns
`default_nettype none
module record_sink_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  output logic ready
);
  logic [15:0] lfsr;
  ////////////////////////////////////////
  // Hold forces a long stall so the two-entry buffer fills up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= 16'hACE1;
      ready <= 1'b0;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      ready <= !hold && (lfsr[1:0] != 2'b00);
    end
  end
endmodule : record_sink_model
`default_nettype wire

// ==== verilog/capture_record_defs.svh ====
// Constants for the capture record formatter: header layout, flag positions, limits.
`ifndef CAPTURE_RECORD_DEFS_SVH
`define CAPTURE_RECORD_DEFS_SVH

// Header lengths in bytes
`define CRF_HDR_LEN_POS 16'h0010
`define CRF_HDR_LEN_ETH 16'h0012

// Header byte index of each field
`define CRF_IDX_TS_FIRST 5'h00
`define CRF_IDX_TS_LAST 5'h07
`define CRF_IDX_TYPE 5'h08
`define CRF_IDX_FLAGS 5'h09
`define CRF_IDX_RLEN_HI 5'h0A
`define CRF_IDX_RLEN_LO 5'h0B
`define CRF_IDX_LCTR_HI 5'h0C
`define CRF_IDX_LCTR_LO 5'h0D
`define CRF_IDX_WLEN_HI 5'h0E
`define CRF_IDX_WLEN_LO 5'h0F
`define CRF_IDX_OFFSET 5'h10
`define CRF_IDX_PAD 5'h11

// Flags byte bit positions
`define CRF_FLAG_IFACE_LSB 0
`define CRF_FLAG_VARLEN 2
`define CRF_FLAG_TRUNC 3
`define CRF_FLAG_RX_ERROR 4
`define CRF_FLAG_DP_ERROR 5
`define CRF_FLAG_RSVD_LSB 6

// Values
`define CRF_LOSS_MAX 16'hFFFF
`define CRF_LOSS_RESET 16'h0000
`define CRF_PAD_VALUE 8'h00
`define CRF_FLAGS_RESET 8'h00
`define CRF_TS_ZERO_BITS 4
`define CRF_FIFO_DEPTH 2'h2

`endif

// ==== verilog/capture_record_formatter.sv ====
// Capture record formatter: header build, payload copy, loss count and output buffer.
//
// Contract
// RQ1: Timestamp bytes go out least significant byte first.
// RQ2: Other header fields go out most significant byte first.
// RQ3: Payload bytes are copied in arrival order, never reordered.
// RQ4: Record is 8-byte timestamp, type, flags, rlen, loss count, wire length, body.
// RQ5: Type byte codes 0 to 7 name the record subtypes.
// RQ6: Only type 1 for PoS HDLC and type 2 for Ethernet are produced.
// RQ7: Flags bits 1..0 carry the capture interface number.
// RQ8: Flags bit 2 marks varying record lengths.
// RQ9: Flags bit 3 marks a record cut short for lack of buffer space.
// RQ10: Flags bit 4 marks link receive error, bit 5 internal datapath error.
// RQ11: Record length equals all bytes of the record sent, header included.
// RQ12: A 16-bit count of packets dropped since last record goes in each record.
// RQ13: Loss count starts at zero and sticks at its maximum.
// RQ14: Wire length reports the packet length as seen on the link.
// RQ15: Type 1 record: 16 header bytes, HDLC header, then remaining packet bytes.
// RQ16: Type 2 record: header, offset byte, pad byte, then frame bytes.
// RQ17: Timestamp is taken in hardware when the packet arrives.
// RQ18: Timestamp is one 64-bit fixed-point seconds value since the 1970 epoch.
// RQ19: Upper 32 bits whole seconds, lower 32 bits binary fraction.
// RQ20: Fraction bits below the real resolution are written as zero.
// RQ21: Reserved flags bits 7 and 6 are written as zero.
`timescale 1ns/1ns
`default_nettype none
`include "capture_record_defs.svh"

module capture_record_formatter (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [7:0] IN_DATA,
  input wire logic IN_SOP,
  input wire logic IN_EOP,
  input wire logic [1:0] IN_IFACE,
  input wire logic IN_IS_ETHERNET,
  input wire logic [15:0] IN_CAP_LEN,
  input wire logic [15:0] IN_WIRE_LEN,
  input wire logic IN_RX_ERROR,
  input wire logic IN_DATAPATH_ERROR,
  input wire logic DROP,
  input wire logic [31:0] TS_SECONDS,
  input wire logic [31:0] TS_FRACTION,
  input wire logic VARLEN_MODE,
  input wire logic [7:0] ETH_OFFSET,
  input wire logic [15:0] SPACE_AVAIL,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [7:0] OUT_DATA,
  output logic OUT_SOR,
  output logic OUT_EOR,
  output logic BUSY
);

  //////////////////////////////////////////////////////////////////////////////
  // Header byte selection

  function automatic logic [7:0] header_byte(
    input logic [4:0] idx,
    input logic [63:0] stamp,
    input logic [7:0] code,
    input logic [7:0] flg,
    input logic [15:0] rec_len,
    input logic [15:0] loss_snap,
    input logic [15:0] wire_len,
    input logic [7:0] offs
  );
    logic [7:0] b;
    b = `CRF_PAD_VALUE;
    case (idx)
      `CRF_IDX_TYPE: b = code;
      `CRF_IDX_FLAGS: b = flg;
      `CRF_IDX_RLEN_HI: b = rec_len[15:8]; // [RQ2]
      `CRF_IDX_RLEN_LO: b = rec_len[7:0]; // [RQ2]
      `CRF_IDX_LCTR_HI: b = loss_snap[15:8]; // [RQ2]
      `CRF_IDX_LCTR_LO: b = loss_snap[7:0]; // [RQ2]
      `CRF_IDX_WLEN_HI: b = wire_len[15:8]; // [RQ2]
      `CRF_IDX_WLEN_LO: b = wire_len[7:0]; // [RQ2]
      `CRF_IDX_OFFSET: b = offs; // [RQ16]
      `CRF_IDX_PAD: b = `CRF_PAD_VALUE; // [RQ16]
      default: begin
        // Bytes 0..7: little-endian timestamp
        if (idx <= `CRF_IDX_TS_LAST) begin
          b = stamp[{idx[2:0], 3'b000} +: 8]; // [RQ1] [RQ4]
        end
      end
    endcase
    return b;
  endfunction : header_byte

  //////////////////////////////////////////////////////////////////////////////
  // State

  capture_record_pkg::state_t state;
  capture_record_pkg::state_t next_state;
  capture_record_pkg::record_code_t rec_code;
  logic [63:0] stamp;
  logic [7:0] flags;
  logic [15:0] rlen;
  logic [15:0] lctr;
  logic [15:0] wlen;
  logic [7:0] offset;
  logic [4:0] hidx;
  logic [4:0] hlast;
  logic [15:0] body_left;
  logic [15:0] loss;

  //////////////////////////////////////////////////////////////////////////////
  // Record start decode

  wire start = CLK_EN && (state == capture_record_pkg::ST_IDLE) && IN_VALID && IN_SOP;
  wire [15:0] hdr_len = IN_IS_ETHERNET ? `CRF_HDR_LEN_ETH : `CRF_HDR_LEN_POS; // [RQ15] [RQ16]
  wire [16:0] full_len = {1'b0, hdr_len} + {1'b0, IN_CAP_LEN};
  wire too_long = full_len > {1'b0, SPACE_AVAIL};
  // Header always goes out whole, even if the space cannot hold it
  wire space_short = SPACE_AVAIL < hdr_len;
  wire [15:0] next_rlen = space_short ? hdr_len : (too_long ? SPACE_AVAIL : full_len[15:0]); // [RQ11]
  wire [15:0] next_body = next_rlen - hdr_len; // [RQ4]
  wire [31:0] frac_mask = ~((32'h0000_0001 << `CRF_TS_ZERO_BITS) - 32'h0000_0001);
  // Seconds high word, fraction low word, dead fraction bits cleared
  wire [63:0] next_stamp = {TS_SECONDS, TS_FRACTION & frac_mask}; // [RQ17] [RQ18] [RQ19] [RQ20]
  wire [4:0] next_hlast = IN_IS_ETHERNET ? `CRF_IDX_PAD : `CRF_IDX_WLEN_LO;
  wire capture_record_pkg::record_code_t next_code = IN_IS_ETHERNET ?
    capture_record_pkg::ethernet_record_code : capture_record_pkg::pos_hdlc_record_code; // [RQ5] [RQ6]

  logic [7:0] next_flags;
  always_comb begin
    next_flags = `CRF_FLAGS_RESET; // [RQ21]
    next_flags[`CRF_FLAG_IFACE_LSB +: 2] = IN_IFACE; // [RQ7]
    next_flags[`CRF_FLAG_VARLEN] = VARLEN_MODE; // [RQ8]
    next_flags[`CRF_FLAG_TRUNC] = too_long; // [RQ9]
    next_flags[`CRF_FLAG_RX_ERROR] = IN_RX_ERROR; // [RQ10]
    next_flags[`CRF_FLAG_DP_ERROR] = IN_DATAPATH_ERROR; // [RQ10]
    next_flags[`CRF_FLAG_RSVD_LSB +: 2] = 2'b00; // [RQ21]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output buffer, two entries

  logic [9:0] fifo_mem [0:1];
  logic wptr;
  logic rptr;
  logic [1:0] fcount;
  wire fifo_ready = fcount != `CRF_FIFO_DEPTH;
  wire pop = CLK_EN && (fcount != 2'h0) && OUT_READY;

  wire in_head = state == capture_record_pkg::ST_HEAD;
  wire in_body = state == capture_record_pkg::ST_BODY;
  wire in_skip = state == capture_record_pkg::ST_SKIP;
  wire head_last = hidx == hlast;
  wire body_last = body_left == 16'h0001;
  wire push_req = in_head || (in_body && IN_VALID);
  wire push = CLK_EN && push_req && fifo_ready;
  wire take = CLK_EN && IN_VALID && ((in_body && fifo_ready) || in_skip);

  wire [7:0] hbyte = header_byte(hidx, stamp, rec_code, flags, rlen, lctr, wlen, offset);
  wire head_sor = hidx == `CRF_IDX_TS_FIRST;
  wire head_eor = head_last && (body_left == 16'h0000);
  // Early end of packet still closes the record cleanly
  wire body_eor = body_last || IN_EOP;
  wire [9:0] push_word = in_head ? {head_sor, head_eor, hbyte} : {1'b0, body_eor, IN_DATA}; // [RQ3]

  assign IN_READY = CLK_EN && ((in_body && fifo_ready) || in_skip);
  assign OUT_VALID = CLK_EN && (fcount != 2'h0);
  assign OUT_DATA = fifo_mem[rptr][7:0];
  assign OUT_EOR = fifo_mem[rptr][8];
  assign OUT_SOR = fifo_mem[rptr][9];
  assign BUSY = (state != capture_record_pkg::ST_IDLE) || (fcount != 2'h0);

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fifo_mem[0] <= 10'h000;
      fifo_mem[1] <= 10'h000;
      wptr <= 1'b0;
      rptr <= 1'b0;
      fcount <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem[wptr] <= push_word;
        wptr <= ~wptr;
      end
      if (pop) begin
        rptr <= ~rptr;
      end
      case ({push, pop})
        2'b10: fcount <= fcount + 2'h1;
        2'b01: fcount <= fcount - 2'h1;
        default: fcount <= fcount;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    next_state = state;
    case (state)
      capture_record_pkg::ST_IDLE: begin
        if (start) begin
          next_state = capture_record_pkg::ST_HEAD;
        end
      end
      capture_record_pkg::ST_HEAD: begin
        if (push && head_last) begin
          // Nothing left to copy: swallow the whole packet
          next_state = (body_left == 16'h0000) ? capture_record_pkg::ST_SKIP : capture_record_pkg::ST_BODY;
        end
      end
      capture_record_pkg::ST_BODY: begin
        if (take) begin
          if (IN_EOP) begin
            next_state = capture_record_pkg::ST_IDLE;
          end else if (body_last) begin
            next_state = capture_record_pkg::ST_SKIP; // [RQ9]
          end
        end
      end
      capture_record_pkg::ST_SKIP: begin
        if (take && IN_EOP) begin
          next_state = capture_record_pkg::ST_IDLE;
        end
      end
      default: next_state = capture_record_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= capture_record_pkg::ST_IDLE;
    end else if (CLK_EN) begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Record fields, latched when the packet first shows

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stamp <= 64'h0000_0000_0000_0000;
      rec_code <= capture_record_pkg::pos_hdlc_record_code;
      flags <= `CRF_FLAGS_RESET;
      rlen <= 16'h0000;
      lctr <= `CRF_LOSS_RESET;
      wlen <= 16'h0000;
      offset <= 8'h00;
      hlast <= 5'h00;
    end else if (start) begin
      stamp <= next_stamp; // [RQ17]
      rec_code <= next_code; // [RQ6]
      flags <= next_flags;
      rlen <= next_rlen; // [RQ11]
      lctr <= loss; // [RQ12]
      wlen <= IN_WIRE_LEN; // [RQ14]
      offset <= ETH_OFFSET;
      hlast <= next_hlast; // [RQ15] [RQ16]
    end
  end

  // Header index and payload budget
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hidx <= 5'h00;
      body_left <= 16'h0000;
    end else if (start) begin
      hidx <= `CRF_IDX_TS_FIRST;
      body_left <= next_body; // [RQ4]
    end else if (push && in_head) begin
      hidx <= hidx + 5'h01;
    end else if (push && in_body) begin
      body_left <= body_left - 16'h0001; // [RQ3]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Loss counter

  // A drop in the start cycle belongs to the next record, never lost
  wire [15:0] loss_inc = (loss == `CRF_LOSS_MAX) ? loss : loss + 16'h0001; // [RQ13]
  wire [15:0] next_loss = start ? (DROP ? 16'h0001 : `CRF_LOSS_RESET) : (DROP ? loss_inc : loss); // [RQ12]

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      loss <= `CRF_LOSS_RESET; // [RQ13]
    end else if (CLK_EN) begin
      loss <= next_loss;
    end
  end

endmodule : capture_record_formatter
`default_nettype wire

// ==== verilog/capture_record_pkg.sv ====
// Types for the capture record formatter.
`default_nettype none
package capture_record_pkg;

  typedef enum logic [7:0] {
    legacy_record_code = 8'h00,
    pos_hdlc_record_code = 8'h01,
    ethernet_record_code = 8'h02,
    cell_record_code = 8'h03,
    reassembled_frame_code = 8'h04,
    multichannel_hdlc_code = 8'h05,
    multichannel_raw_code = 8'h06,
    multichannel_cell_code = 8'h07
  } record_code_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HEAD = 2'b01,
    ST_BODY = 2'b10,
    ST_SKIP = 2'b11
  } state_t;

endpackage : capture_record_pkg
`default_nettype wire
